// *** hw/uhft_pkg.sv ***
package uhft_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FRAME_US = 1000;     // Frame marker period.
  localparam int unsigned SUSPEND_US = 3000;   // Idle time before suspend done.
  localparam int unsigned FRAME_CYC = (CLK_HZ / 1_000_000) * FRAME_US;
  localparam int unsigned SUSPEND_CYC = (CLK_HZ / 1_000_000) * SUSPEND_US;
  localparam int TMR_W = 18;

  // ----------------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_RECV_FIFO = 5'h01;
  localparam logic [4:0] REG_SEND_FIFO = 5'h02;
  localparam logic [4:0] REG_SETUP = 5'h04;
  localparam logic [4:0] REG_SEND_COUNT = 5'h05;
  localparam logic [4:0] REG_HOST_FLAGS = 5'h06;
  localparam logic [4:0] REG_HOST_ENABLE = 5'h07;
  localparam logic [4:0] REG_MODE = 5'h08;
  localparam logic [4:0] REG_HOST_CTRL = 5'h09;
  localparam logic [4:0] REG_RESULT = 5'h0a;
  localparam logic [4:0] REG_SUPPLY_FLAGS = 5'h0b;
  localparam logic [4:0] REG_SUPPLY_ENABLE = 5'h0c;
  localparam logic [4:0] REG_FRAME_LO = 5'h0d;
  localparam logic [4:0] REG_FRAME_HI = 5'h0e;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int HF_SUSPEND_DONE = 0;
  localparam int HF_SEND_FREE = 3;
  localparam int HF_FRAME_SENT = 6;
  localparam int MODE_SLOW_RATE = 1;
  localparam int MODE_MARKER_EN = 3;
  localparam int HC_FRAME_CLEAR = 0;
  localparam int HC_RECV_ZERO = 4;
  localparam int HC_RECV_ONE = 5;
  localparam int HC_SEND_ZERO = 6;
  localparam int HC_SEND_ONE = 7;
  localparam int RS_RECV_TOG = 4;
  localparam int RS_SEND_TOG = 5;
  localparam int SF_RISE = 0;
  localparam int SF_FALL = 1;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int FRAME_W = 11;
  localparam int COUNT_W = 7;
  localparam logic [7:0] HOST_ENABLE_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] SUPPLY_ENABLE_RST = 2'h0;
  localparam logic [4:0] CRC5_INIT = 5'h1f;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  localparam logic [1:0] SEND_BUFFERS = 2'h2;

  // Frame marker sequencer states.
  typedef enum logic [1:0] {MK_IDLE, MK_WAIT, MK_SEND} uhft_mark_e;

endpackage

// *** hw/uhft_top.sv ***
`timescale 1ns/1ns

// ------------------------------------------------------------------------
// Send data buffer
// ------------------------------------------------------------------------
module uhft_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,              // System clock.
  input wire logic rst_i,                // Asynchronous reset.
  input wire logic in_valid_i,           // Write request.
  output logic in_ready_o,               // Room for a word.
  input wire logic [WIDTH-1:0] in_data_i, // Write data.
  output logic out_valid_o,              // Word available.
  input wire logic out_ready_i,          // Reader takes the word.
  output logic [WIDTH-1:0] out_data_o    // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } uhft_fifo_s;

  uhft_fifo_s q;
  uhft_fifo_s d;
  logic push;
  logic pop;

  // Handshakes come straight from the occupancy count.
  assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update; pointers wrap at the depth.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ------------------------------------------------------------------------
// Host frame, toggle and setup block
// ------------------------------------------------------------------------
module uhft_top #(
  parameter int FRAME_CYCLES = uhft_pkg::FRAME_CYC,
  parameter int SUSPEND_CYCLES = uhft_pkg::SUSPEND_CYC,
  parameter int SEND_DEPTH = 8
) (
  input wire logic clock_i,                    // System clock.
  input wire logic rst_i,                      // Asynchronous reset.
  input wire logic [4:0] reg_addr_i,           // Register number.
  input wire logic reg_wr_i,                   // Register write strobe.
  input wire logic reg_rd_i,                   // Register read strobe.
  input wire logic [7:0] reg_wdata_i,          // Write data.
  output logic [7:0] reg_rdata_o,              // Read data, next cycle.
  output logic send_fifo_ready_o,              // Send buffer has room.
  output logic tx_valid_o,                     // Send byte available.
  output logic [7:0] tx_data_o,                // Send byte.
  input wire logic tx_ready_i,                 // Engine takes a byte.
  output logic send_commit_o,                  // Byte count committed.
  output logic [uhft_pkg::COUNT_W-1:0] send_count_o, // Committed count.
  input wire logic send_ack_i,                 // A send buffer was freed.
  input wire logic send_tog_adv_i,             // Advance send toggle.
  input wire logic recv_tog_adv_i,             // Advance receive toggle.
  output logic send_toggle_o,                  // Send data toggle.
  output logic recv_toggle_o,                  // Receive data toggle.
  input wire logic result_valid_i,             // Transfer finished.
  input wire logic [3:0] result_code_i,        // Transfer outcome.
  output logic slow_rate_select_o,             // Low speed host.
  output logic marker_valid_o,                 // Frame marker in progress.
  output logic marker_sof_o,                   // One: SOF, zero: EOP.
  output logic [uhft_pkg::FRAME_W-1:0] marker_frame_o, // Frame number.
  output logic [4:0] marker_crc_o,             // CRC5 of frame number.
  input wire logic marker_done_i,              // Marker signaling done.
  input wire logic bus_busy_i,                 // Bus not idle.
  input wire logic [2:0] setup_idx_i,          // Setup byte index.
  output logic [7:0] setup_byte_o,             // Setup byte, next cycle.
  input wire logic supply_sense_pin_i,         // Supply comparator.
  input wire logic bus_reset_i,                // Bus reset seen.
  output logic irq_o                           // Interrupt pin, high active.
);
  import uhft_pkg::*;

  typedef struct packed {
    uhft_mark_e st;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] idle;
    logic [FRAME_W-1:0] frame;
    logic mk_sof;
    logic [4:0] mk_crc;
    logic stog;
    logic rtog;
    logic [7:0] hien;
    logic [7:0] mode;
    logic sbav;
    logic susdn;
    logic frame_f;
    logic [1:0] sien;
    logic [1:0] sirq;
    logic sprev;
    logic [3:0] result;
    logic [COUNT_W-1:0] sbc;
    logic commit;
    logic [1:0] busy;
    logic [7:0][7:0] setup;
    logic [2:0] swp;
    logic [2:0] srp;
    logic [7:0] rdata;
    logic [7:0] sbyte;
  } uhft_state_s;

  uhft_state_s q;
  uhft_state_s d;
  logic wr_send_fifo;
  logic wr_hctl;

  // CRC5 over the frame number, least significant bit first.
  function automatic logic [4:0] crc5(input logic [FRAME_W-1:0] v);
    logic [4:0] c;
    c = CRC5_INIT;
    for (int i = 0; i < FRAME_W; i++) begin
      if (c[4] ^ v[i]) begin
        c = {c[3:0], 1'b0} ^ CRC5_POLY;
      end else begin
        c = {c[3:0], 1'b0};
      end
    end
    return ~c;
  endfunction

  // Send bytes pass through the buffer; its ready reaches the CPU side.
  assign wr_send_fifo = reg_wr_i && (reg_addr_i == REG_SEND_FIFO);
  assign wr_hctl = reg_wr_i && (reg_addr_i == REG_HOST_CTRL);

  uhft_fifo #(.WIDTH(8), .DEPTH(SEND_DEPTH)) u_send_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(wr_send_fifo),
    .in_ready_o(send_fifo_ready_o),
    .in_data_i(reg_wdata_i),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(tx_data_o)
  );

  // Outputs taken from the state register.
  assign reg_rdata_o = q.rdata;
  assign send_commit_o = q.commit;
  assign send_count_o = q.sbc;
  assign send_toggle_o = q.stog;
  assign recv_toggle_o = q.rtog;
  assign slow_rate_select_o = q.mode[MODE_SLOW_RATE];
  assign marker_valid_o = (q.st == MK_SEND);
  assign marker_sof_o = q.mk_sof;
  assign marker_frame_o = q.frame;
  assign marker_crc_o = q.mk_crc;
  assign setup_byte_o = q.sbyte;
  assign irq_o = (q.susdn & q.hien[HF_SUSPEND_DONE]) |
                 (q.sbav & q.hien[HF_SEND_FREE]) |
                 (q.frame_f & q.hien[HF_FRAME_SENT]) |
                 (|(q.sirq & q.sien));

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Toggle advances before register writes, hardware sets last so a set beats a clear.
  always_comb begin
    d = q;
    d.commit = 1'b0;
    d.sprev = supply_sense_pin_i;
    d.sbyte = q.setup[setup_idx_i];
    // Engine advances both toggles on its own between transfers.
    if (send_tog_adv_i) begin
      d.stog = ~q.stog;
    end
    if (recv_tog_adv_i) begin
      d.rtog = ~q.rtog;
    end
    if (result_valid_i) begin
      d.result = result_code_i;
    end
    // Register writes.
    if (reg_wr_i) begin
      if (reg_addr_i == REG_SETUP) begin
        d.setup[q.swp] = reg_wdata_i;
        d.swp = q.swp + 1'b1;
      end else if (reg_addr_i == REG_SEND_COUNT) begin
        d.sbc = reg_wdata_i[COUNT_W-1:0];
        d.commit = 1'b1;
        d.sbav = 1'b0;
      end else if (reg_addr_i == REG_HOST_FLAGS) begin
        if (reg_wdata_i[HF_SUSPEND_DONE]) begin
          d.susdn = 1'b0;
        end
        if (reg_wdata_i[HF_FRAME_SENT]) begin
          d.frame_f = 1'b0;
        end
      end else if (reg_addr_i == REG_HOST_ENABLE) begin
        d.hien = reg_wdata_i;
      end else if (reg_addr_i == REG_MODE) begin
        d.mode = reg_wdata_i;
      end else if (reg_addr_i == REG_HOST_CTRL) begin
        if (reg_wdata_i[HC_SEND_ONE] && !reg_wdata_i[HC_SEND_ZERO]) begin
          d.stog = 1'b1;
        end else if (reg_wdata_i[HC_SEND_ZERO] &&
                     !reg_wdata_i[HC_SEND_ONE]) begin
          d.stog = 1'b0;
        end
        if (reg_wdata_i[HC_RECV_ONE] && !reg_wdata_i[HC_RECV_ZERO]) begin
          d.rtog = 1'b1;
        end else if (reg_wdata_i[HC_RECV_ZERO] &&
                     !reg_wdata_i[HC_RECV_ONE]) begin
          d.rtog = 1'b0;
        end
      end else if (reg_addr_i == REG_SUPPLY_FLAGS) begin
        d.sirq = q.sirq & ~reg_wdata_i[1:0];
      end else if (reg_addr_i == REG_SUPPLY_ENABLE) begin
        d.sien = reg_wdata_i[1:0];
      end
    end
    // Send buffer bookkeeping: two buffers, freed by the engine.
    if (d.commit && !send_ack_i) begin
      d.busy = q.busy + 1'b1;
    end else if (send_ack_i && !d.commit && q.busy != '0) begin
      d.busy = q.busy - 1'b1;
    end
    if (send_ack_i || (q.commit && q.busy != SEND_BUFFERS)) begin
      d.sbav = 1'b1;
    end
    // Register reads.
    d.rdata = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == REG_SETUP) begin
        d.rdata = q.setup[q.srp];
        d.srp = q.srp + 1'b1;
      end else if (reg_addr_i == REG_SEND_COUNT) begin
        d.rdata = {1'b0, q.sbc};
      end else if (reg_addr_i == REG_HOST_FLAGS) begin
        d.rdata[HF_SUSPEND_DONE] = q.susdn;
        d.rdata[HF_SEND_FREE] = q.sbav;
        d.rdata[HF_FRAME_SENT] = q.frame_f;
      end else if (reg_addr_i == REG_HOST_ENABLE) begin
        d.rdata = q.hien;
      end else if (reg_addr_i == REG_MODE) begin
        d.rdata = q.mode;
      end else if (reg_addr_i == REG_RESULT) begin
        d.rdata = {2'h0, q.stog, q.rtog, q.result};
      end else if (reg_addr_i == REG_SUPPLY_FLAGS) begin
        d.rdata = {6'h00, q.sirq};
      end else if (reg_addr_i == REG_SUPPLY_ENABLE) begin
        d.rdata = {6'h00, q.sien};
      end else if (reg_addr_i == REG_FRAME_LO) begin
        d.rdata = q.frame[7:0];
      end else if (reg_addr_i == REG_FRAME_HI) begin
        d.rdata = {5'h00, q.frame[FRAME_W-1:8]};
      end
    end
    // Frame marker sequencer; the timer runs whenever the sequencer is out of MK_IDLE.
    if (q.st != MK_IDLE) begin
      d.timer = (q.timer == TMR_W'(FRAME_CYCLES - 1)) ? '0 : q.timer + 1'b1;
    end
    case (q.st)
      MK_IDLE: begin
        d.timer = '0;
        if (q.mode[MODE_MARKER_EN]) begin
          d.st = MK_WAIT;
        end
      end
      MK_WAIT: begin
        if (!q.mode[MODE_MARKER_EN]) begin
          d.st = MK_IDLE;
        end else if (q.timer == TMR_W'(FRAME_CYCLES - 1)) begin
          d.st = MK_SEND;
          d.mk_sof = !q.mode[MODE_SLOW_RATE];
          d.mk_crc = crc5(q.frame);
        end
      end
      MK_SEND: begin
        if (marker_done_i) begin
          d.st = q.mode[MODE_MARKER_EN] ? MK_WAIT : MK_IDLE;
          if (q.mk_sof) begin
            d.frame = q.frame + 1'b1;
            d.frame_f = 1'b1;
          end
        end
      end
      default: begin
        d.st = MK_IDLE;
      end
    endcase
    if (wr_hctl && reg_wdata_i[HC_FRAME_CLEAR]) begin
      d.frame = '0;
    end
    // Suspend done after the bus has stayed idle for the full time.
    if (q.st == MK_IDLE && !bus_busy_i) begin
      if (q.idle != TMR_W'(SUSPEND_CYCLES)) begin
        d.idle = q.idle + 1'b1;
      end
      if (q.idle == TMR_W'(SUSPEND_CYCLES - 1)) begin
        d.susdn = 1'b1;
      end
    end else begin
      d.idle = '0;
    end
    // Supply comparator edges, in every operating mode.
    if (supply_sense_pin_i && !q.sprev) begin
      d.sirq[SF_RISE] = 1'b1;
    end
    if (!supply_sense_pin_i && q.sprev) begin
      d.sirq[SF_FALL] = 1'b1;
    end
    if (bus_reset_i) begin
      d.hien = HOST_ENABLE_RST;
    end
  end

  // State register.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= MK_IDLE;
      q.sbav <= 1'b1;
      q.hien <= HOST_ENABLE_RST;
      q.mode <= MODE_RST;
      q.sien <= SUPPLY_ENABLE_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_TOG_ONE: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_hctl && reg_wdata_i[HC_SEND_ONE] && !reg_wdata_i[HC_SEND_ZERO]
    |=> send_toggle_o)
    else $error("Send toggle not set to one.");

  AST_TOG_BOTH: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_hctl && reg_wdata_i[HC_RECV_ONE] && reg_wdata_i[HC_RECV_ZERO] &&
    !recv_tog_adv_i |=> $stable(recv_toggle_o))
    else $error("Receive toggle changed on double set.");

  AST_TOG_ADV: assert property (@(posedge clock_i) disable iff (rst_i)
    send_tog_adv_i && !wr_hctl |=> send_toggle_o != $past(send_toggle_o))
    else $error("Send toggle did not advance.");

  AST_FIRST_MARK: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(marker_valid_o) |->
    $past(q.timer) == TMR_W'(FRAME_CYCLES - 1) && $past(q.st) == MK_WAIT)
    else $error("Marker started before a full period.");

  AST_MARK_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    marker_valid_o && !marker_done_i |=> marker_valid_o)
    else $error("Marker dropped before done.");

  AST_FRAME_INC: assert property (@(posedge clock_i) disable iff (rst_i)
    marker_valid_o && marker_done_i && marker_sof_o && !wr_hctl
    |=> marker_frame_o == FRAME_W'($past(marker_frame_o) + 1'b1) &&
    q.frame_f)
    else $error("Frame not counted after SOF.");

  AST_RESULT_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    !result_valid_i |=> $stable(q.result))
    else $error("Result code changed without a transfer.");

  AST_SUSPEND: assert property (@(posedge clock_i) disable iff (rst_i)
    q.st == MK_IDLE && !bus_busy_i &&
    q.idle == TMR_W'(SUSPEND_CYCLES - 1)
    |=> q.susdn && q.idle == TMR_W'(SUSPEND_CYCLES))
    else $error("Suspend done not raised.");

  AST_RISE: assert property (@(posedge clock_i) disable iff (rst_i)
    supply_sense_pin_i && !q.sprev |=> q.sirq[SF_RISE])
    else $error("Supply rise not flagged.");

  AST_COMMIT: assert property (@(posedge clock_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == REG_SEND_COUNT && !q.commit && !send_ack_i
    |=> !q.sbav && send_commit_o)
    else $error("Byte count write did not commit.");

  AST_SETUP_WR: assert property (@(posedge clock_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == REG_SETUP
    |=> q.setup[$past(q.swp)] == $past(reg_wdata_i))
    else $error("Setup byte not stored.");
endmodule

// *** dv/uhft_peer.sv ***
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Engine side peer
// ----------------------------------------------------------------------
// Finishes each frame marker after a short or a long delay, and takes
// send bytes unless the bench asks it to stall.
module uhft_peer (
  input wire logic clock_i,        // System clock.
  input wire logic rst_i,          // Asynchronous reset.
  input wire logic slow_i,         // Long marker signaling.
  input wire logic stall_i,        // Refuse send bytes.
  input wire logic marker_valid_i, // Marker in progress.
  output logic marker_done_o,      // Marker signaling done.
  output logic tx_ready_o          // Takes a send byte.
);
  logic [3:0] cnt_q;

  // A stalled engine holds off the send buffer.
  assign tx_ready_o = !stall_i;

  // Count marker cycles and report done once for each marker.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      marker_done_o <= 1'b0;
    end else begin
      marker_done_o <= marker_valid_i && cnt_q == (slow_i ? 4'hc : 4'h3);
      if (!marker_valid_i) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// *** dv/usb_host_frame_toggle_setup_tb.sv ***
`timescale 1ns/1ns

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module usb_host_frame_toggle_setup_tb;
  import uhft_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic stall = 1'b1, stadv = 1'b0, rtadv = 1'b0, rval = 1'b0, ack = 1'b0;
  logic pin = 1'b0, breset = 1'b0, busy = 1'b0, send_commit_o, irq_o;
  logic [4:0] addr = 5'h00;
  logic [7:0] wd = 8'h00, rdata, tx_data_o, setup_byte_o;
  logic [3:0] code = 4'h0;
  logic [2:0] sidx = 3'h0;
  logic [6:0] send_count_o;
  logic [10:0] marker_frame_o;
  logic [4:0] marker_crc_o;
  logic send_fifo_ready_o, tx_valid_o, tx_ready, send_toggle_o;
  logic recv_toggle_o, marker_valid_o, marker_sof_o, mdone, slow_o;
  int mismatches = 0;
  int checks = 0;

  // Clock of 50 MHz.
  always #10 clock_i = ~clock_i;

  uhft_top #(.FRAME_CYCLES(20), .SUSPEND_CYCLES(40), .SEND_DEPTH(8)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .send_fifo_ready_o(send_fifo_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready),
    .send_commit_o(send_commit_o), .send_count_o(send_count_o),
    .send_ack_i(ack), .send_tog_adv_i(stadv), .recv_tog_adv_i(rtadv),
    .send_toggle_o(send_toggle_o), .recv_toggle_o(recv_toggle_o),
    .result_valid_i(rval), .result_code_i(code), .slow_rate_select_o(slow_o),
    .marker_valid_o(marker_valid_o), .marker_sof_o(marker_sof_o),
    .marker_frame_o(marker_frame_o), .marker_crc_o(marker_crc_o),
    .marker_done_i(mdone), .bus_busy_i(busy), .setup_idx_i(sidx),
    .setup_byte_o(setup_byte_o), .supply_sense_pin_i(pin),
    .bus_reset_i(breset), .irq_o(irq_o));

  uhft_peer peer_u (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
    .stall_i(stall), .marker_valid_i(marker_valid_o), .marker_done_o(mdone),
    .tx_ready_o(tx_ready));

  // ----------------------------------------------------------------------
  // Bus cycles and helpers
  // ----------------------------------------------------------------------
  // One register write; the strobe is high for exactly one edge.
  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clock_i) addr = a; wd = d; wr = 1'b1;
    @(negedge clock_i) wr = 1'b0;
  endtask

  // One register read; data stands for the cycle after the strobe.
  task automatic rreg(input logic [4:0] a, output logic [7:0] d);
    @(negedge clock_i) addr = a; rd = 1'b1;
    @(negedge clock_i) rd = 1'b0;
    d = rdata;
  endtask

  // Waits a bounded time for the marker level to reach lvl.
  task automatic wait_mk(input logic lvl, output int n);
    n = 0;
    while (marker_valid_o !== lvl && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 200) begin
      mismatches++;
      $display("BAD %0t marker wait ran out", $time);
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values and both data toggles, set, held and advanced.
  task automatic t_toggle();
    logic [7:0] w [8] = '{8'h80, 8'hc0, 8'h00, 8'h40, 8'hc0, 8'h20, 8'h30,
      8'h10};
    logic [7:0] es = 8'b11100000;
    logic [7:0] er = 8'b00000110;
    logic [7:0] d;
    rreg(REG_RESULT, d);
    `CHK(d, 8'h00)
    rreg(REG_FRAME_LO, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 8; i++) begin
      wreg(REG_HOST_CTRL, w[i]);
      rreg(REG_RESULT, d);
      `CHK(d[5:4], {es[7-i], er[7-i]})
      `CHK({send_toggle_o, recv_toggle_o}, {es[7-i], er[7-i]})
    end
    @(negedge clock_i) stadv = 1'b1;
    @(negedge clock_i) stadv = 1'b0;
    `CHK({send_toggle_o, recv_toggle_o}, 2'b10)
    rtadv = 1'b1;
    @(negedge clock_i) rtadv = 1'b0;
    `CHK({send_toggle_o, recv_toggle_o}, 2'b11)
    // Save both toggles, clobber them, then restore the saved values.
    rreg(REG_RESULT, d);
    wreg(REG_HOST_CTRL, 8'h50);
    wreg(REG_HOST_CTRL, {d[5], ~d[5], d[4], ~d[4], 4'h0});
    `CHK({send_toggle_o, recv_toggle_o}, 2'b11)
    $display("toggle test done");
  endtask

  // Setup payload written eight times and read back both ways.
  task automatic t_setup();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) wreg(REG_SETUP, 8'h10 + 8'(i * 3));
    for (int i = 0; i < 8; i++) begin
      rreg(REG_SETUP, d);
      `CHK(d, 8'h10 + 8'(i * 3))
      sidx = 3'(i);
      @(negedge clock_i);
      `CHK(setup_byte_o, 8'h10 + 8'(i * 3))
    end
    $display("setup test done");
  endtask

  // Supply edges, the fall enable and write-one clearing.
  task automatic t_supply();
    logic [7:0] d;
    @(negedge clock_i) pin = 1'b1;
    repeat (3) @(negedge clock_i);
    pin = 1'b0;
    rreg(REG_SUPPLY_FLAGS, d);
    `CHK(d[1:0], 2'h3)
    `CHK(irq_o, 1'b0)
    wreg(REG_SUPPLY_ENABLE, 8'h02);
    `CHK(irq_o, 1'b1)
    wreg(REG_SUPPLY_FLAGS, 8'h02);
    rreg(REG_SUPPLY_FLAGS, d);
    `CHK({irq_o, d[1:0]}, 3'h1)
    wreg(REG_SUPPLY_FLAGS, 8'h01);
    rreg(REG_SUPPLY_FLAGS, d);
    `CHK(d[1:0], 2'h0)
    $display("supply test done");
  endtask

  // Frame markers, frame count, low rate, stop and suspend done.
  task automatic t_marker();
    logic [7:0] d;
    int n;
    time t1;
    wreg(REG_HOST_FLAGS, 8'h01);
    @(negedge clock_i) rval = 1'b1; code = 4'h5;
    @(negedge clock_i) rval = 1'b0;
    wreg(REG_MODE, 8'h08);
    wait_mk(1'b1, n);
    t1 = $time;
    `CHK(n >= 19 && n <= 24, 1'b1)
    `CHK({marker_sof_o, marker_frame_o}, 12'h800)
    `CHK(marker_crc_o, 5'h08)
    wait_mk(1'b0, n);
    wait_mk(1'b1, n);
    `CHK($time - t1, 64'd400)
    `CHK(marker_frame_o, 11'h001)
    `CHK(marker_crc_o, 5'h17)
    wait_mk(1'b0, n);
    rreg(REG_HOST_FLAGS, d);
    `CHK(d[6], 1'b1)
    rreg(REG_RESULT, d);
    `CHK(d[3:0], 4'h5)
    slow = 1'b1;
    wreg(REG_MODE, 8'h0a);
    wait_mk(1'b1, n);
    `CHK({slow_o, marker_sof_o}, 2'b10)
    wreg(REG_MODE, 8'h00);
    `CHK(marker_valid_o, 1'b1)
    wait_mk(1'b0, n);
    `CHK(n, 12)
    rreg(REG_FRAME_LO, d);
    `CHK(d, 8'h02)
    rreg(REG_HOST_FLAGS, d);
    `CHK(d[0], 1'b0)
    // A one-cycle burst of bus activity restarts the idle count.
    repeat (30) @(negedge clock_i);
    busy = 1'b1;
    @(negedge clock_i) busy = 1'b0;
    repeat (20) @(negedge clock_i);
    rreg(REG_HOST_FLAGS, d);
    `CHK(d[0], 1'b0)
    repeat (20) @(negedge clock_i);
    rreg(REG_HOST_FLAGS, d);
    `CHK({marker_valid_o, d[0]}, 2'b01)
    wreg(REG_HOST_ENABLE, 8'h01);
    `CHK(irq_o, 1'b1)
    wreg(REG_HOST_FLAGS, 8'h00);
    `CHK(irq_o, 1'b1)
    wreg(REG_HOST_FLAGS, 8'h01);
    `CHK(irq_o, 1'b0)
    wreg(REG_HOST_CTRL, 8'h01);
    rreg(REG_FRAME_LO, d);
    `CHK(d, 8'h00)
    wreg(REG_HOST_ENABLE, 8'hff);
    @(negedge clock_i) breset = 1'b1;
    @(negedge clock_i) breset = 1'b0;
    rreg(REG_HOST_ENABLE, d);
    `CHK(d, 8'h00)
    $display("marker test done");
  endtask

  // Send buffer filled until it refuses, committed twice, then drained.
  task automatic t_send();
    logic [7:0] d;
    int n = 0;
    while (send_fifo_ready_o === 1'b1 && n < 12) begin
      wreg(REG_SEND_FIFO, 8'ha0 + 8'(n));
      n++;
    end
    `CHK(n, 8)
    wreg(REG_SEND_FIFO, 8'h55);
    wreg(REG_SEND_COUNT, 8'h08);
    `CHK({send_commit_o, send_count_o}, 8'h88)
    rreg(REG_HOST_FLAGS, d);
    `CHK(d[3], 1'b1)
    wreg(REG_SEND_COUNT, 8'h08);
    rreg(REG_HOST_FLAGS, d);
    `CHK(d[3], 1'b0)
    @(negedge clock_i) ack = 1'b1;
    @(negedge clock_i) ack = 1'b0;
    stall = 1'b0;
    for (int i = 0; i < 8; i++) begin
      `CHK({tx_valid_o, tx_data_o}, {1'b1, 8'ha0 + 8'(i)})
      @(negedge clock_i);
    end
    `CHK(tx_valid_o, 1'b0)
    rreg(REG_HOST_FLAGS, d);
    `CHK(d[3], 1'b1)
    $display("send test done");
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(negedge clock_i);
    rst_i = 1'b0;
    t_toggle();
    t_setup();
    t_supply();
    t_marker();
    t_send();
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule
